/* File: core/cmp_regs.svh */
// Timing constants for the current-mode pulse-width controller
`ifndef CMP_REGS_SVH
`define CMP_REGS_SVH
`define CMP_CLK_NS 20
`define CMP_OSC_KHZ 100
`define CMP_PERIOD_CYC ((1000000 / `CMP_OSC_KHZ) / `CMP_CLK_NS)
`define CMP_DMAX_NUM 3
`define CMP_DMAX_DEN 4
`define CMP_DEAD_NS 156
`define CMP_DEAD_CYC ((`CMP_DEAD_NS + `CMP_CLK_NS - 1) / `CMP_CLK_NS)
`define CMP_LEB_NORM_NS 220
`define CMP_LEB_BURST_NS 180
`define CMP_LEB_NORM_CYC ((`CMP_LEB_NORM_NS + `CMP_CLK_NS - 1) / `CMP_CLK_NS)
`define CMP_LEB_BURST_CYC ((`CMP_LEB_BURST_NS + `CMP_CLK_NS - 1) / `CMP_CLK_NS)
`define CMP_SS_STEP_US 300
`define CMP_SS_STEP_CYC ((`CMP_SS_STEP_US * 1000) / `CMP_CLK_NS)
`define CMP_SS_STEPS 32
`define CMP_SS_TOTAL_MS 10
`define CMP_JIT_PCT 4
`define CMP_JIT_MS 4
`define CMP_JIT_DEV_CYC ((`CMP_PERIOD_CYC * `CMP_JIT_PCT) / 100)
`define CMP_JIT_STEP_CYC \
  ((`CMP_JIT_MS * 1000000 / `CMP_CLK_NS) / (4 * `CMP_JIT_DEV_CYC))
`define CMP_SENSE_GAIN_X100 325
`endif

/* File: core/cmp_pkg.sv */
// Types for the current-mode pulse-width controller
package cmp_pkg;
  typedef enum logic [1:0] {
    CMP_OFF = 2'b00,
    CMP_DEAD = 2'b01,
    CMP_ON = 2'b11,
    CMP_HOLD = 2'b10
  } cmp_phase_e;
  typedef struct packed {
    logic duty_trip;
    logic softstart_trip;
    logic peak_trip;
    logic burst_trip;
  } cmp_trips_s;
endpackage

/* File: core/cmp_pwm_ctrl.sv */
// Current-mode pulse-width controller with soft start and jitter
// Notes on behaviour
// - Sense above feedback ends on-time
// - Ramp switch closed during off interval
// - Gate held off about 156 ns
// - Blanked sense scaled by 3.25
// - Ramp sum feeds duty and softstart comparators
// - Soft start begins at supply turn-on
// - Soft-start level rises in 32 steps
// - Soft-start counter advances every 300 us
// - Soft start ends, sink off afterwards
// - Duty grows from zero to maximum
// - Soft start reruns at every restart
// - Nominal switching frequency 100 kHz
// - On-time at most 0.75 of period
// - Jitter +-4 percent, 4 ms, after softstart
// - Oscillator sets latch, comparators clear it
// - Cleared latch turns gate off immediately
// - Gate low while supply undervoltage
// - Peak limit trip ends the pulse
// - Sense ignored during leading-edge blanking
// - Burst limit active only in burst
// - Blanking 220 ns normal, 180 ns burst
// - Supply drop resets soft-start counter
`timescale 1ns/1ps
`include "cmp_regs.svh"
module cmp_pwm_ctrl
  import cmp_pkg::*;
#(
  parameter int PERIOD_CYC = `CMP_PERIOD_CYC,
  parameter int SS_STEP_CYC = `CMP_SS_STEP_CYC,
  parameter int SS_STEPS = `CMP_SS_STEPS,
  parameter int JIT_STEP_CYC = `CMP_JIT_STEP_CYC,
  parameter int JIT_DEV_CYC = `CMP_JIT_DEV_CYC
) (
  input wire logic clock_i, // 50 MHz system clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic supply_ok_i, // Supply above turn-on, lockout off
  input wire logic burst_mode_i, // Active burst mode entered
  input wire cmp_trips_s trips_i, // Comparator results, synchronous
  output logic gate_o, // Gate drive to power switch
  output logic ramp_switch_o, // Ramp switch closed when high
  output logic spike_blanking_o, // Sense path blanked when high
  output logic [4:0] softstart_level_o, // Soft-start step level
  output logic softstart_done_o // Soft start finished, sink off
);
  localparam int CW = 12;
  localparam int SW = $clog2(SS_STEP_CYC + 1);
  localparam int JW = $clog2(JIT_STEP_CYC + 1);
  localparam int DW = 8;
  localparam logic [DW-1:0] DEAD_N = DW'(`CMP_DEAD_CYC);
  localparam logic [DW-1:0] LEB_N = DW'(`CMP_LEB_NORM_CYC);
  localparam logic [DW-1:0] LEB_B = DW'(`CMP_LEB_BURST_CYC);
  localparam logic [CW-1:0] JDEV = CW'(JIT_DEV_CYC);
  localparam logic [CW-1:0] PER0 = CW'(PERIOD_CYC);

  // Maximum on-window length for a given period
  function automatic logic [CW-1:0] dmax(input logic [CW-1:0] per);
    logic [CW+1:0] p;
    p = {2'b00, per} * (CW+2)'(`CMP_DMAX_NUM);
    dmax = CW'(p / (CW+2)'(`CMP_DMAX_DEN));
  endfunction

  logic [CW-1:0] osc_cnt_r, osc_cnt_nxt;
  logic [CW-1:0] period_r;
  logic signed [CW:0] jit_r;
  logic jit_up_r;
  logic [JW-1:0] jit_div_r;
  logic [SW-1:0] ss_div_r;
  logic [5:0] ss_cnt_r;
  logic latch_r;
  cmp_phase_e phase_r, phase_nxt;
  logic [DW-1:0] dead_r, leb_r;

  // Oscillator: start pulse and max-duty window
  wire osc_wrap = (osc_cnt_r >= period_r - CW'(1));
  wire osc_start = supply_ok_i & osc_wrap;
  wire on_window = (osc_cnt_r < dmax(period_r));
  assign osc_cnt_nxt = osc_wrap ? '0 : osc_cnt_r + CW'(1);

  // Soft-start status and step tick
  wire ss_done = (ss_cnt_r >= 6'(SS_STEPS));
  wire ss_tick = (ss_div_r == SW'(SS_STEP_CYC - 1));

  // Blanking and reset sources; burst limit gated by burst mode
  wire blank = (leb_r != '0);
  wire burst_gate = trips_i.burst_trip & burst_mode_i;
  wire ss_gate = trips_i.softstart_trip & ~ss_done;
  wire reset_req = ~blank & (trips_i.duty_trip | ss_gate
                   | trips_i.peak_trip | burst_gate)
                   | ~on_window | ~supply_ok_i;
  wire set_req = (phase_r == CMP_DEAD) & (dead_r == DW'(1));

  // Gate phase sequencing
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      CMP_OFF: if (osc_start) phase_nxt = CMP_DEAD;
      CMP_DEAD: if (~supply_ok_i) phase_nxt = CMP_OFF;
        else if (set_req) phase_nxt = reset_req ? CMP_HOLD : CMP_ON;
      CMP_ON: if (reset_req) phase_nxt = CMP_HOLD;
      CMP_HOLD: if (osc_start) phase_nxt = CMP_DEAD;
        else if (~supply_ok_i) phase_nxt = CMP_OFF;
      default: phase_nxt = CMP_OFF;
    endcase
  end

  // Gate cleared in the cycle reset is requested, one cycle before the latch resets
  assign gate_o = latch_r & ~reset_req;
  assign ramp_switch_o = ~latch_r;
  assign spike_blanking_o = blank;
  assign softstart_level_o = ss_done ? 5'h1f : ss_cnt_r[4:0];
  assign softstart_done_o = ss_done;

  // Oscillator counter and jittered period
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_cnt_r <= '0;
      period_r <= PER0;
    end else begin
      osc_cnt_r <= supply_ok_i ? osc_cnt_nxt : '0;
      if (!supply_ok_i || !ss_done)
        period_r <= PER0;
      else if (osc_wrap)
        period_r <= CW'($signed({1'b0, PER0}) + jit_r);
    end
  end

  // Triangular jitter sweep, only after soft start
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      jit_r <= '0;
      jit_up_r <= 1'b1;
      jit_div_r <= '0;
    end else if (!ss_done) begin
      jit_r <= '0;
      jit_div_r <= '0;
    end else if (jit_div_r == JW'(JIT_STEP_CYC - 1)) begin
      jit_div_r <= '0;
      jit_r <= jit_up_r ? jit_r + (CW+1)'(1) : jit_r - (CW+1)'(1);
      if (jit_up_r && jit_r == $signed({1'b0, JDEV}) - 1)
        jit_up_r <= 1'b0;
      else if (!jit_up_r && jit_r == -$signed({1'b0, JDEV}) + 1)
        jit_up_r <= 1'b1;
    end else begin
      jit_div_r <= jit_div_r + JW'(1);
    end
  end

  // Soft-start counter, cleared whenever supply drops
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ss_div_r <= '0;
      ss_cnt_r <= '0;
    end else if (!supply_ok_i) begin
      ss_div_r <= '0;
      ss_cnt_r <= '0;
    end else if (!ss_done) begin
      ss_div_r <= ss_tick ? '0 : ss_div_r + SW'(1);
      if (ss_tick)
        ss_cnt_r <= ss_cnt_r + 6'h01;
    end
  end

  // Phase, dead-time and blanking counters, on-time latch
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_r <= CMP_OFF;
      dead_r <= '0;
      leb_r <= '0;
      latch_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      if ((phase_r == CMP_OFF || phase_r == CMP_HOLD) && osc_start)
        dead_r <= DEAD_N;
      else if (dead_r != '0)
        dead_r <= dead_r - DW'(1);
      if (phase_r == CMP_DEAD && set_req && !reset_req)
        leb_r <= burst_mode_i ? LEB_B : LEB_N;
      else if (leb_r != '0)
        leb_r <= leb_r - DW'(1);
      latch_r <= (phase_nxt == CMP_ON);
    end
  end

  // Assertions share one clock and reset
  default clocking cb_asrt @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  // Oscillator start, dead time and turn-on steps
  sequence s_start;
    (phase_r == CMP_OFF || phase_r == CMP_HOLD) && osc_start;
  endsequence
  sequence s_turn_on;
    phase_r == CMP_DEAD && set_req && !reset_req;
  endsequence
  sequence s_dead_end;
    phase_r == CMP_DEAD && !reset_req;
  endsequence
  a_dead_time: assert property (
    s_start |=> !gate_o [*8])
    else $error("gate rose inside dead time");
  a_dead_load: assert property (
    s_start |=> phase_r == CMP_DEAD && dead_r == DEAD_N)
    else $error("dead time not started");
  a_first_gate: assert property (
    s_start ##8 s_dead_end |=> latch_r)
    else $error("latch not set after dead time");
  a_turn_on: assert property (
    s_turn_on |=> latch_r && spike_blanking_o)
    else $error("turn on without blanking");
  a_set_lose: assert property (
    set_req && reset_req |=> !latch_r && !gate_o)
    else $error("set won over reset");
  a_gate_phase: assert property (
    gate_o |-> phase_r == CMP_ON)
    else $error("gate high outside on phase");

  // Gate termination by comparators and limits
  a_gate_uvlo: assert property (
    !supply_ok_i |-> !gate_o)
    else $error("gate high in undervoltage");
  a_duty_trip: assert property (
    trips_i.duty_trip && !blank |-> !gate_o)
    else $error("duty trip did not end gate");
  a_ss_trip: assert property (
    ss_gate && !blank |-> !gate_o)
    else $error("soft-start trip did not end gate");
  a_peak_trip: assert property (
    trips_i.peak_trip && !blank |-> !gate_o ##1 !gate_o)
    else $error("peak trip did not end pulse");
  a_burst_trip: assert property (
    burst_gate && !blank |-> !gate_o)
    else $error("burst limit did not end gate");
  a_max_duty: assert property (
    !on_window |-> !gate_o)
    else $error("gate beyond max duty");
  a_burst_gate: assert property (
    trips_i.burst_trip && !burst_mode_i && !blank && latch_r
    && !trips_i.duty_trip && !trips_i.peak_trip && !ss_gate
    && on_window && supply_ok_i |-> gate_o)
    else $error("burst limit acted outside burst");
  a_ss_free: assert property (
    trips_i.softstart_trip && ss_done && latch_r && !blank
    && !trips_i.duty_trip && !trips_i.peak_trip && !burst_gate
    && on_window && supply_ok_i |-> gate_o)
    else $error("soft-start limit acted after done");

  // Leading-edge blanking windows
  sequence s_norm_blank;
    $rose(blank) && leb_r == LEB_N;
  endsequence
  sequence s_burst_blank;
    $rose(blank) && leb_r == LEB_B;
  endsequence
  a_blank_ignore: assert property (
    $rose(latch_r) |-> gate_o || !on_window || !supply_ok_i)
    else $error("sense not blanked at turn on");
  a_leb_norm: assert property (
    s_turn_on && !burst_mode_i |=> leb_r == LEB_N)
    else $error("normal blanking length wrong");
  a_leb_burst: assert property (
    s_turn_on && burst_mode_i |=> leb_r == LEB_B)
    else $error("burst blanking length wrong");
  a_blank_hold: assert property (
    $rose(blank) |-> blank [*8])
    else $error("blanking ended early");
  a_blank_norm_end: assert property (
    s_norm_blank |-> ##10 blank ##1 !blank)
    else $error("normal blanking window wrong");
  a_blank_burst_end: assert property (
    s_burst_blank |-> ##8 blank ##1 !blank)
    else $error("burst blanking window wrong");

  // Ramp switch follows the on-time latch
  a_ramp_switch: assert property (
    !on_window |=> ramp_switch_o)
    else $error("ramp switch open past max duty");
  a_ramp_closed: assert property (
    gate_o |-> !ramp_switch_o)
    else $error("ramp switch closed during pulse");

  // Soft-start counter
  a_ss_reset: assert property (
    !supply_ok_i |=> ss_cnt_r == 6'h00)
    else $error("soft-start counter not cleared");
  a_ss_step: assert property (
    supply_ok_i && ss_tick && !ss_done |=> ss_cnt_r == $past(ss_cnt_r) + 1)
    else $error("soft-start counter did not step");
  a_ss_pace: assert property (
    $changed(ss_cnt_r) && $past(supply_ok_i) |-> $past(ss_tick))
    else $error("soft-start counter stepped off pace");
  a_ss_stays: assert property (
    ss_done && supply_ok_i |=> ss_done)
    else $error("soft start left done state");
  a_ss_range: assert property (
    ss_cnt_r <= 6'(SS_STEPS))
    else $error("soft-start counter overran");

  // Oscillator count and jitter
  a_osc_wrap: assert property (
    osc_wrap && supply_ok_i |=> osc_cnt_r == '0)
    else $error("oscillator did not wrap");
  a_osc_count: assert property (
    supply_ok_i && !osc_wrap |=> osc_cnt_r == $past(osc_cnt_r) + 1)
    else $error("oscillator did not count");
  a_period_nom: assert property (
    !ss_done |-> period_r == PER0)
    else $error("jitter before soft start end");
  a_jit_idle: assert property (
    !ss_done |=> jit_r == '0)
    else $error("jitter offset during soft start");
  a_jit_range: assert property (
    jit_r <= $signed({1'b0, JDEV})
    && jit_r >= -$signed({1'b0, JDEV}))
    else $error("jitter beyond its span");
endmodule

/* File: test/cmp_switch_model.sv */
// Power switch and sense path model raising comparator trips
`timescale 1ns/1ps
module cmp_switch_model
  import cmp_pkg::*;
(
  input wire logic clock_i, // System clock
  input wire logic reset_n_i, // Async reset, active low
  input wire logic gate_i, // Gate drive from controller
  input wire logic [9:0] trip_cyc_i, // On-time until trip
  input wire logic [3:0] trip_sel_i, // Comparators that trip
  output cmp_trips_s trips_o // Comparator results
);
  logic [9:0] on_cnt_r;
  // Sensed current ramps only while the switch conducts
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      on_cnt_r <= 10'h000;
    end else begin
      on_cnt_r <= gate_i ? on_cnt_r + 10'h001 : 10'h000;
    end
  end
  // Registered ramp keeps the gate path free of loops
  assign trips_o = cmp_trips_s'((on_cnt_r >= trip_cyc_i) ? trip_sel_i : 4'h0);
endmodule

/* File: test/cmp_pwm_ctrl_tb_top.sv */
// Testbench for the current-mode pulse-width controller
`timescale 1ns/1ps
module cmp_pwm_ctrl_tb_top
  import cmp_pkg::*;
;
  localparam int SS_CYC = 40;
  logic clock_i, reset_n_i, supply_ok_i, burst_mode_i, gate_o, ramp_o;
  logic blank_o, done_o;
  logic [4:0] level_o;
  logic [9:0] trip_cyc;
  logic [3:0] trip_sel;
  cmp_trips_s trips;
  int n_errors = 0;
  int checks_done = 0;
  int t_on, t_blank, t_gap, t_ramp, p_on, n;
  // Controller with short soft-start steps
  cmp_pwm_ctrl #(.SS_STEP_CYC(SS_CYC), .JIT_STEP_CYC(10)) i_dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .supply_ok_i(supply_ok_i),
    .burst_mode_i(burst_mode_i), .trips_i(trips), .gate_o(gate_o),
    .ramp_switch_o(ramp_o), .spike_blanking_o(blank_o),
    .softstart_level_o(level_o), .softstart_done_o(done_o));
  // Far side: switch, sense resistor, comparators
  cmp_switch_model i_model (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .gate_i(gate_o), .trip_cyc_i(trip_cyc), .trip_sel_i(trip_sel),
    .trips_o(trips));
  // System clock, 20 ns period
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Compare and count
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Drive inputs at a rising edge, let them settle
  task automatic set_in(logic sup, logic bst, logic [9:0] cyc, logic [3:0] sel);
    @(posedge clock_i);
    supply_ok_i <= sup;
    burst_mode_i <= bst;
    trip_cyc <= cyc;
    trip_sel <= sel;
    repeat (2) @(negedge clock_i);
  endtask
  // Wait for a gate pulse and measure it
  task automatic pulse();
    n = 0;
    t_on = 0;
    t_blank = 0;
    t_ramp = 0;
    while (gate_o !== 1'b1 && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    t_gap = n;
    while (gate_o === 1'b1 && t_on < 2000) begin
      t_blank += (blank_o === 1'b1);
      t_ramp += (ramp_o === 1'b0);
      @(negedge clock_i);
      t_on++;
    end
  endtask
  task automatic t_reset();
    @(negedge clock_i);
    check("gate_rst", gate_o, 0);
    check("ramp_rst", ramp_o, 1);
    check("level_rst", level_o, 0);
    @(posedge clock_i);
    reset_n_i <= 1'b1;
    n = 0;
    repeat (600) @(negedge clock_i) n += (gate_o !== 1'b0);
    check("gate_uvlo", n, 0);
    $display("t_reset finished");
  endtask
  task automatic t_timing();
    set_in(1, 0, 10'h3ff, 4'h0);
    pulse();
    p_on = t_on;
    check("ramp_open", t_ramp, t_on);
    check("blank_norm", t_blank, 11);
    check("max_duty", t_on inside {[300:375]}, 1);
    pulse();
    check("period", p_on + t_gap, 500);
    set_in(1, 1, 10'h3ff, 4'h0);
    pulse();
    check("blank_burst", t_blank, 9);
    $display("t_timing finished");
  endtask
  task automatic t_softstart();
    set_in(0, 0, 10'h3ff, 4'h0);
    check("level_clr", level_o, 0);
    check("done_clr", done_o, 0);
    set_in(1, 0, 10'h3ff, 4'h0);
    for (int i = 0; i < 2; i++) begin
      n = 0;
      while (level_o === 5'(i) && n < 2000) begin
        @(negedge clock_i);
        n++;
      end
      check("ss_step", level_o, i + 1);
    end
    check("ss_pace", n, SS_CYC);
    n = 0;
    while (done_o !== 1'b1 && n < 4000) begin
      @(negedge clock_i);
      n++;
    end
    check("ss_end", n inside {[1100:1300]}, 1);
    check("ss_top", level_o, 31);
    $display("t_softstart finished");
  endtask
  task automatic t_trips();
    logic [3:0] sels [3] = '{4'h8, 4'h2, 4'h1};
    set_in(0, 0, 10'd30, 4'h4);
    set_in(1, 0, 10'd30, 4'h4);
    pulse();
    check("ss_trip", t_on, 30);
    foreach (sels[i]) begin
      set_in(1, sels[i] == 4'h1, 10'd30, sels[i]);
      pulse();
      check("trip_ontime", t_on, 30);
    end
    set_in(1, 0, 10'd30, 4'h1);
    pulse();
    check("burst_off", t_on > 30, 1);
    set_in(1, 0, 10'd5, 4'h8);
    pulse();
    check("blank_trip", t_on, 11);
    n = 0;
    while (done_o !== 1'b1 && n < 4000) begin
      @(negedge clock_i);
      n++;
    end
    set_in(1, 0, 10'd30, 4'h4);
    pulse();
    check("ss_after", t_on > 30, 1);
    set_in(1, 0, 10'd0, 4'h8);
    pulse();
    check("set_lose", t_on, 0);
    $display("t_trips finished");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset_n_i = 1'b0;
    supply_ok_i = 1'b0;
    burst_mode_i = 1'b0;
    trip_cyc = 10'h3ff;
    trip_sel = 4'h0;
    repeat (2) @(posedge clock_i);
    t_reset();
    t_timing();
    t_softstart();
    t_trips();
    end_of_test();
  end
  // Watchdog
  initial begin
    #(20 * 20000);
    n_errors++;
    end_of_test();
  end
endmodule
